// file: hw/bss_boot_start_select.sv
// reset-time boot start selection: strap capture, start address, mapping
`default_nettype none
`timescale 1ns/10ps

module bss_boot_start_select
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_program_store_enable_n,
  input wire logic i_external_access_pin,
  input wire logic i_ale_pin,
  input wire logic [bss_pkg::BYTE_W-1:0] i_hw_security_byte,
  input wire logic i_security_byte_valid,
  input wire logic [bss_pkg::BYTE_W-1:0] i_user_boot_vector_byte,
  input wire logic i_user_boot_vector_valid,
  input wire logic i_api_active,
  input wire logic [bss_pkg::ADDR_W-1:0] i_code_addr,
  output logic o_boot_valid,
  output logic o_hw_boot_cond,
  output logic o_boot_space_enable,
  output logic o_start_in_boot,
  output logic [bss_pkg::BYTE_W-1:0] o_flash_control_reg,
  output logic [bss_pkg::ADDR_W-1:0] o_start_pc,
  output logic [bss_pkg::ADDR_W-1:0] o_user_boot_entry,
  output logic o_user_boot_present,
  output logic o_sel_boot_flash
);
  import bss_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_boot_window(input logic [ADDR_W-1:0] addr);
    in_boot_window = (addr >= BOOT_WIN_LO) && (addr <= BOOT_WIN_HI);
  endfunction : in_boot_window

  function automatic logic [BYTE_W-1:0] eff_security
  (
    input logic valid,
    input logic [BYTE_W-1:0] raw
  );
    // an unprogrammed byte reads as the shipped value: loader first
    eff_security = valid ? raw : SEC_SHIPPED;
  endfunction : eff_security

  // ----------------------------------------------------------------
  // decode of the live pins
  // ----------------------------------------------------------------
  bss_straps_t straps;
  bss_choice_t live_choice;
  logic [BYTE_W-1:0] sec_byte;
  logic jump_bit;
  logic [BYTE_W-1:0] ubv;

  // an open ALE pin reads high through the board pull-up
  assign straps = '{program_store_enable_n: i_program_store_enable_n,
    external_access_pin: i_external_access_pin,
    ale_pin: i_ale_pin};
  assign sec_byte = eff_security(i_security_byte_valid,
    i_hw_security_byte);
  assign jump_bit = sec_byte[JUMP_BIT_POS];
  assign ubv = i_user_boot_vector_valid ? i_user_boot_vector_byte
    : UBV_DEFAULT;

  bss_start_decode u_decode
  (
    .i_straps(straps),
    .i_boot_jump_bit(jump_bit),
    .o_choice(live_choice)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bss_state_t s_q;
  bss_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    case (s_q.phase)
      BSS_SAMPLE:
      begin
        // first edge after release stands for the reset falling edge
        s_d.choice = live_choice;
        s_d.user_boot_entry = {ubv, UBV_ENTRY_LOW};
        s_d.user_boot_present = (ubv != UBV_DEFAULT);
        s_d.boot_valid = 1'b1;
        s_d.phase = BSS_RUN;
      end
      BSS_RUN:
      begin
        // pins are ignored from here until the next reset
        s_d.choice = s_q.choice;
      end
      default:
      begin
        s_d.phase = BSS_SAMPLE;
        s_d.boot_valid = 1'b0;
      end
    endcase
    // loader code owns the top window while it runs or calls routines
    s_d.sel_boot_flash = s_q.boot_valid && in_boot_window(i_code_addr)
      && (i_api_active || s_q.choice.start_in_boot);
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_boot_valid = s_q.boot_valid;
  assign o_hw_boot_cond = s_q.choice.hw_cond;
  assign o_boot_space_enable = s_q.choice.boot_space_enable;
  assign o_start_in_boot = s_q.choice.start_in_boot;
  assign o_flash_control_reg = s_q.choice.flash_control_reg;
  assign o_start_pc = s_q.choice.start_pc;
  assign o_user_boot_entry = s_q.user_boot_entry;
  assign o_user_boot_present = s_q.user_boot_present;
  assign o_sel_boot_flash = s_q.sel_boot_flash;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  logic first_q;
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
    end
  end

  a_enable_from_jump:
    assert property (first_q |=> o_boot_space_enable == $past(jump_bit))
    else $error("boot-space enable not loaded from jump bit");

  a_hw_cond_detect:
    assert property (first_q |=> o_hw_boot_cond ==
      $past(!i_program_store_enable_n && i_external_access_pin
      && i_ale_pin))
    else $error("hardware boot condition wrongly sampled");

  a_hw_boot_start:
    assert property (o_boot_valid && o_hw_boot_cond |->
      o_flash_control_reg == FLASH_CTL_HW_BOOT
      && o_start_pc == PC_BOOT_FLASH)
    else $error("hardware boot did not select loader start");

  a_hw_over_jump:
    assert property (o_boot_valid && o_hw_boot_cond |-> o_start_in_boot)
    else $error("hardware boot overridden by jump bit");

  a_normal_flash_ctl:
    assert property (o_boot_valid && !o_hw_boot_cond |->
      o_flash_control_reg == FLASH_CTL_NORMAL)
    else $error("flash control not F0h without hardware boot");

  a_user_start:
    assert property (o_boot_valid && !o_hw_boot_cond
      && o_boot_space_enable |-> o_start_pc == PC_USER_FLASH)
    else $error("user start address wrong");

  a_loader_start:
    assert property (o_boot_valid && !o_hw_boot_cond
      && !o_boot_space_enable |-> o_start_pc == PC_BOOT_FLASH)
    else $error("loader start address wrong");

  a_entry_byte:
    assert property (first_q |=> o_user_boot_entry ==
      {$past(ubv), UBV_ENTRY_LOW})
    else $error("user boot entry not vector byte then 00h");

  a_ubv_default:
    assert property (first_q && !i_user_boot_vector_valid |=>
      !o_user_boot_present && o_user_boot_entry[ADDR_W-1:BYTE_W]
      == UBV_DEFAULT)
    else $error("user boot vector default not applied");

  a_shipped_loader:
    assert property (first_q && !i_security_byte_valid |=>
      o_start_in_boot && !o_boot_space_enable)
    else $error("shipped part did not enter loader");

  a_map_window:
    assert property (o_boot_valid && i_api_active
      && in_boot_window(i_code_addr) |=> o_sel_boot_flash)
    else $error("boot flash not mapped during routine call");

  a_map_outside:
    assert property (!in_boot_window(i_code_addr) |=> !o_sel_boot_flash)
    else $error("boot flash mapped outside its window");

  a_choice_held:
    assert property (o_boot_valid |=> $stable(o_start_pc)
      && $stable(o_flash_control_reg) && $stable(o_hw_boot_cond)
      && $stable(o_boot_space_enable) && o_boot_valid)
    else $error("boot choice changed after capture");

endmodule : bss_boot_start_select
`default_nettype wire

// file: hw/bss_start_decode.sv
// combinational decode of straps and jump bit into the boot choice
`default_nettype none
`timescale 1ns/10ps
module bss_start_decode
(
  input wire bss_pkg::bss_straps_t i_straps,
  input wire logic i_boot_jump_bit,
  output var bss_pkg::bss_choice_t o_choice
);
  import bss_pkg::*;

  // ----------------------------------------------------------------
  // decision
  // ----------------------------------------------------------------
  always_comb
  begin
    o_choice.hw_cond = !i_straps.program_store_enable_n
      && i_straps.external_access_pin
      && i_straps.ale_pin;
    o_choice.boot_space_enable = i_boot_jump_bit;
    if (o_choice.hw_cond)
    begin
      // jump bit is ignored: the loader runs anyway
      o_choice.flash_control_reg = FLASH_CTL_HW_BOOT;
      o_choice.start_pc = PC_BOOT_FLASH;
      o_choice.start_in_boot = 1'b1;
    end
    else
    begin
      o_choice.flash_control_reg = FLASH_CTL_NORMAL;
      if (i_boot_jump_bit)
      begin
        o_choice.start_pc = PC_USER_FLASH;
        o_choice.start_in_boot = 1'b0;
      end
      else
      begin
        o_choice.start_pc = PC_BOOT_FLASH;
        o_choice.start_in_boot = 1'b1;
      end
    end
  end

endmodule : bss_start_decode
`default_nettype wire

// file: shared/bss_pkg.sv
// constants and types for the reset-time boot start selection block
`default_nettype none
package bss_pkg;

  // ----------------------------------------------------------------
  // widths, field positions and values
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned JUMP_BIT_POS = 6;

  localparam logic [BYTE_W-1:0] FLASH_CTL_HW_BOOT = 8'h00;
  localparam logic [BYTE_W-1:0] FLASH_CTL_NORMAL = 8'hf0;
  localparam logic [ADDR_W-1:0] PC_USER_FLASH = 16'h0000;
  localparam logic [ADDR_W-1:0] PC_BOOT_FLASH = 16'hf800;
  localparam logic [ADDR_W-1:0] BOOT_WIN_LO = 16'hf800;
  localparam logic [ADDR_W-1:0] BOOT_WIN_HI = 16'hffff;
  localparam logic [BYTE_W-1:0] UBV_DEFAULT = 8'hfc;
  localparam logic [BYTE_W-1:0] UBV_ENTRY_LOW = 8'h00;
  // security byte of a part shipped with the loader: jump bit clear
  localparam logic [BYTE_W-1:0] SEC_SHIPPED = 8'hbf;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BSS_SAMPLE = 2'h0,
    BSS_RUN = 2'h1
  } bss_phase_t;

  typedef struct packed
  {
    logic program_store_enable_n;
    logic external_access_pin;
    logic ale_pin;
  } bss_straps_t;

  typedef struct packed
  {
    logic hw_cond;
    logic boot_space_enable;
    logic start_in_boot;
    logic [BYTE_W-1:0] flash_control_reg;
    logic [ADDR_W-1:0] start_pc;
  } bss_choice_t;

  typedef struct packed
  {
    bss_phase_t phase;
    logic boot_valid;
    bss_choice_t choice;
    logic [ADDR_W-1:0] user_boot_entry;
    logic user_boot_present;
    logic sel_boot_flash;
  } bss_state_t;

endpackage : bss_pkg
`default_nettype wire

// file: verification/bss_board_straps.sv
// board-side model of the strap pins around reset
`timescale 1ns/10ps
`default_nettype none
module bss_board_straps
(
  input wire logic i_sys_clk,
  input wire logic i_drive,
  input wire bss_pkg::bss_straps_t i_level,
  output var bss_pkg::bss_straps_t o_pins
);
  import bss_pkg::*;
  logic last_access;

  initial last_access = 1'b0;

  always @(posedge i_sys_clk)
    if (i_drive)
      last_access <= i_level.external_access_pin;

  // released access pin shows the inverse, so a stale sample shows up
  always_comb
  begin
    if (i_drive)
      o_pins = i_level;
    else
      o_pins = {1'b1, ~last_access, 1'b1};
  end
endmodule : bss_board_straps
`default_nettype wire

// file: verification/bss_boot_start_select_tb_top.sv
// self-checking bench for the boot start selection block
`timescale 1ns/10ps
`default_nettype none
module bss_boot_start_select_tb_top;
  import bss_pkg::*;
  typedef struct packed
  {
    bss_straps_t straps;
    logic sec_ok;
    logic [7:0] sec;
    logic vec_ok;
    logic [7:0] vec;
    logic hw;
    logic bse;
    logic [7:0] fctl;
    logic [15:0] pc;
  } bss_row_t;
  // straps are store-enable, access, ale
  bss_row_t rows [8] = '{
    {3'b011, 1'b1, 8'h40, 1'b1, 8'h12, 1'b1, 1'b1, 8'h00, 16'hf800},
    {3'b011, 1'b1, 8'hbf, 1'b0, 8'h55, 1'b1, 1'b0, 8'h00, 16'hf800},
    {3'b111, 1'b1, 8'h40, 1'b1, 8'hfc, 1'b0, 1'b1, 8'hf0, 16'h0000},
    {3'b111, 1'b1, 8'hbf, 1'b1, 8'ha0, 1'b0, 1'b0, 8'hf0, 16'hf800},
    {3'b001, 1'b1, 8'h40, 1'b1, 8'h00, 1'b0, 1'b1, 8'hf0, 16'h0000},
    {3'b010, 1'b1, 8'hff, 1'b1, 8'hfc, 1'b0, 1'b1, 8'hf0, 16'h0000},
    {3'b111, 1'b0, 8'h40, 1'b1, 8'h7e, 1'b0, 1'b0, 8'hf0, 16'hf800},
    {3'b110, 1'b1, 8'hbf, 1'b0, 8'h00, 1'b0, 1'b0, 8'hf0, 16'hf800}};
  logic clk, rst, drive, sec_ok, vec_ok, api_on;
  logic [7:0] sec, vec, fctl;
  logic [15:0] addr, pc, entry;
  logic valid, hw, bse, in_boot, present, sel;
  bss_straps_t level, pins;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  bss_board_straps board (.i_sys_clk(clk), .i_drive(drive),
    .i_level(level), .o_pins(pins));

  bss_boot_start_select DUT (.i_sys_clk(clk), .i_reset(rst),
    .i_program_store_enable_n(pins.program_store_enable_n),
    .i_external_access_pin(pins.external_access_pin),
    .i_ale_pin(pins.ale_pin), .i_hw_security_byte(sec),
    .i_security_byte_valid(sec_ok), .i_user_boot_vector_byte(vec),
    .i_user_boot_vector_valid(vec_ok), .i_api_active(api_on),
    .i_code_addr(addr), .o_boot_valid(valid), .o_hw_boot_cond(hw),
    .o_boot_space_enable(bse), .o_start_in_boot(in_boot),
    .o_flash_control_reg(fctl), .o_start_pc(pc),
    .o_user_boot_entry(entry), .o_user_boot_present(present),
    .o_sel_boot_flash(sel));

  // ----
  // checking tasks
  // ----
  task automatic test_done();
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk_flag(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_flag

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
    input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_val

  // straps flip while reset is high; pins and bytes change after capture
  task automatic run_row(input int r);
    bss_row_t w;
    logic [7:0] vb;
    w = rows[r];
    vb = w.vec_ok ? w.vec : UBV_DEFAULT;
    @(negedge clk);
    rst = 1'b1;
    drive = 1'b1;
    level = bss_straps_t'(~w.straps);
    sec_ok = w.sec_ok;
    sec = w.sec;
    vec_ok = w.vec_ok;
    vec = w.vec;
    @(negedge clk);
    chk_flag(valid, 1'b0, "valid in reset");
    level = w.straps;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    drive = 1'b0;
    sec = ~w.sec;
    vec = ~w.vec;
    sec_ok = ~w.sec_ok;
    repeat (3) @(negedge clk);
    chk_flag(valid, 1'b1, "valid");
    chk_flag(hw, w.hw, "hw cond");
    chk_flag(bse, w.bse, "boot space");
    chk_flag(in_boot, w.pc === PC_BOOT_FLASH, "in boot");
    chk_val({8'h00, fctl}, {8'h00, w.fctl}, "flash ctrl");
    chk_val(pc, w.pc, "start pc");
    chk_val(entry, {vb, UBV_ENTRY_LOW}, "entry");
    chk_flag(present, vb !== UBV_DEFAULT, "present");
  endtask : run_row

  task automatic map_chk(input logic [15:0] a, input logic api, input logic e);
    addr = a;
    api_on = api;
    @(negedge clk);
    chk_flag(sel, e, "boot window");
  endtask : map_chk

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_errors++;
      test_done();
    end
  end

  initial
  begin
    rst = 1'b1;
    drive = 1'b0;
    level = '0;
    {sec_ok, vec_ok, api_on} = 3'h0;
    {sec, vec, addr} = 32'h0;
    repeat (4) @(negedge clk);
    chk_val(pc, 16'h0000, "pc in reset");
    for (int r = 0; r < 8; r++)
      run_row(r);
    run_row(2);
    map_chk(16'hf800, 1'b1, 1'b1);
    map_chk(16'hffff, 1'b1, 1'b1);
    map_chk(16'hf7ff, 1'b1, 1'b0);
    map_chk(16'hf900, 1'b0, 1'b0);
    run_row(1);
    map_chk(16'hf800, 1'b0, 1'b1);
    map_chk(16'h0000, 1'b1, 1'b0);
    test_done();
  end
endmodule : bss_boot_start_select_tb_top
`default_nettype wire
